// >>> verilog/atcr_defines.vh
// register offsets, field positions, reset values and timing constants for the auxiliary timer block
`ifndef ATCR_DEFINES_VH
`define ATCR_DEFINES_VH

`define ATCR_ADDR_CONTROL     16'hff46
`define ATCR_ADDR_TIMER       16'hff48
`define ATCR_ADDR_CAPTURE_RELOAD_REG      16'hff4a
`define ATCR_ADDR_FLAGS       16'hff4c
`define ATCR_CONTROL_RESET    16'h0000
`define ATCR_INSEL_LSB        0
`define ATCR_INSEL_MSB        2
`define ATCR_MODE_BIT         3
`define ATCR_RUN_BIT          6
`define ATCR_DIR_BIT          7
`define ATCR_CEDGE_LSB        12
`define ATCR_CEDGE_MSB        13
`define ATCR_CLEAR_BIT        14
`define ATCR_CAPEN_BIT        15
`define ATCR_CONTROL_MASK     16'hf0cf
`define ATCR_FLAG_WRAP        0
`define ATCR_FLAG_CAPTURE     1
`define ATCR_FLAG_WRAP_EN     2
`define ATCR_FLAG_CAPTURE_EN  3
`define ATCR_PRESCALE_BASE    8
`define ATCR_PRESCALE_WIDTH   10
`define ATCR_SETTLE_STATES    4

`endif

// >>> verilog/atcr_aux_timer.v
// auxiliary 16-bit up/down timer with capture/reload register
`timescale 1ns/10ps
`default_nettype none
`include "atcr_defines.vh"

module atcr_aux_timer
#(
  parameter WIDTH = 16
)
(
  input  wire             clock,
  input  wire             nrst,
  input  wire [15:0]      addr,
  input  wire [15:0]      wdata,
  input  wire             wr_en,
  input  wire             rd_en,
  output reg  [15:0]      rdata,
  input  wire             core_toggle_latch,
  input  wire             core_wrap,
  input  wire             core_reload_enable,
  output reg              core_load,
  output reg  [WIDTH-1:0] core_load_value,
  input  wire             capture_trigger_pin,
  output wire             aux_irq,
  output wire             capture_irq
);

  // register map, as software sees it over the plain strobe port:
  //   control   - mode, run, direction, input select, capture edge, clear, capture enable
  //   timer     - the live auxiliary count, readable and writable at any time
  //   capreal   - the capture/reload word shared by capture and core reload
  //   flags     - wrap flag, capture flag and their two interrupt enables
  // every register resets to zero, so after reset the timer is stopped,
  // counts up in timer mode with the fastest prescaler, and capture is off
  //
  // control register layout:
  //   bits 2..0   input select; prescaler choice in timer mode, edge choice in counter mode
  //   bit  3      mode; low picks timer mode, high picks counter mode
  //   bits 5..4   unused, always read as zero
  //   bit  6      run; low freezes the count in either mode
  //   bit  7      direction; low counts up, high counts down
  //   bits 11..8  unused, always read as zero
  //   bits 13..12 capture edge select; none, rising, falling or both
  //   bit  14     clear on capture; zeroes the count right after a capture
  //   bit  15     capture enable; gates the copy into the capture word and the clear, not the flag
  // unused control bits are masked on write, so software sees zeros there
  //
  // flags register layout:
  //   bit 0       wrap flag, set when the count rolls over either way
  //   bit 1       capture flag, set on every selected pin edge
  //   bit 2       wrap interrupt enable
  //   bit 3       capture interrupt enable
  // both flags are plain read/write bits; software clears them by writing
  // zero, and a hardware set in the same cycle as that write wins, so an
  // event that lands on the clearing write is never lost
  //
  // timer mode:
  //   a ten bit prescaler runs freely from reset; a tick is taken when its
  //   low three-plus-select bits are all ones, which gives one tick every
  //   eight times two-to-the-select cycles; the prescaler is never cleared
  //   by a control write, so the first tick after a start may come early by
  //   up to one prescaler period; this keeps the divider to a bare counter
  //
  // counter mode:
  //   the core timer's toggle latch is sampled every cycle and compared with
  //   its previous sample; a change only counts when the core wrap pulse is
  //   high in the same cycle, because the core moves its latch and raises
  //   its wrap pulse together; a latch move made by software comes with no
  //   wrap pulse and is therefore ignored
  //   the select field picks rising, falling or both latch edges; select
  //   values with the top bit clear, and the value with only the top bit
  //   set, leave the counter idle
  //   chaining the core timer, its latch and this counter gives a 32-bit or
  //   33-bit count, and each side keeps its own direction bit
  //
  // capture path:
  //   the capture pin passes two flip-flops before any logic sees it, then
  //   a third flop holds the previous sample for edge detection; an edge is
  //   thus seen three clocks after the pin moves, and only once
  //   a pin that moves again within that window can hide a pulse, so the
  //   source must hold each level for a few cycles
  //   on a selected edge the capture flag is set in every case; the copy of
  //   the count into the capture word happens only with capture enabled,
  //   and the clear of the count follows only when both enable and clear
  //   bits are set; the copy takes the value before the clear
  //
  // core reload:
  //   with the reload enable high, each core wrap raises the load strobe one
  //   cycle later together with the capture word; the core keeps its own
  //   wrap flag, and the capture flag is not touched by a reload
  //
  // priority inside one cycle:
  //   a software write of the count beats a capture clear, which beats a
  //   tick; a capture beats a software write of the capture word, so a
  //   measured value is never overwritten by a late write
  //
  // read data:
  //   read data is registered and valid only in the cycle after the read
  //   strobe; at every other time it is held at zero so that a shared read
  //   bus can be built from a plain or-gate

  // registers, control register fields and internal state
  reg  [15:0]      aux_timer_control;
  reg  [WIDTH-1:0] aux_timer;
  reg  [WIDTH-1:0] capture_reload_reg;
  reg              aux_wrap_request;
  reg              capture_request_flag;
  reg              aux_irq_enable;
  reg              capture_irq_enable;
  reg  [`ATCR_PRESCALE_WIDTH-1:0] prescale;
  reg              pin_sync1;
  reg              pin_sync2;
  reg              pin_prev;
  reg              toggle_prev;
  reg  [WIDTH-1:0] next_aux_timer;
  reg              tick;
  reg              wraps;
  wire [2:0]       aux_input_select;
  wire             aux_mode_select;
  wire             aux_run;
  wire             aux_direction;
  wire [1:0]       capture_edge_select;
  wire             clear_on_capture;
  wire             capture_enable;
  wire             pin_rise;
  wire             pin_fall;
  wire             cap_event;
  wire             tog_rise;
  wire             tog_fall;
  wire             timer_tick;
  wire             counter_tick;
  wire             sw_timer_wr;

  assign aux_input_select    = aux_timer_control[`ATCR_INSEL_MSB:`ATCR_INSEL_LSB];
  assign aux_mode_select     = aux_timer_control[`ATCR_MODE_BIT];
  assign aux_run             = aux_timer_control[`ATCR_RUN_BIT];
  assign aux_direction       = aux_timer_control[`ATCR_DIR_BIT];
  assign capture_edge_select = aux_timer_control[`ATCR_CEDGE_MSB:`ATCR_CEDGE_LSB];
  assign clear_on_capture    = aux_timer_control[`ATCR_CLEAR_BIT];
  assign capture_enable      = aux_timer_control[`ATCR_CAPEN_BIT];
  assign sw_timer_wr         = wr_en && (addr == `ATCR_ADDR_TIMER);

  // pulse of the prescaler when its low 3+sel bits are all ones
  function prescale_hit;
    input [`ATCR_PRESCALE_WIDTH-1:0] cnt;
    input [2:0]                      sel;
    reg   [`ATCR_PRESCALE_WIDTH-1:0] mask;
    begin
      mask = ({`ATCR_PRESCALE_WIDTH{1'b1}} >> (3'd7 - sel));
      prescale_hit = ((cnt & mask) == mask);
    end
  endfunction

  // free-running prescaler; divides by 8*2^sel at the hit
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prescale <= {`ATCR_PRESCALE_WIDTH{1'b0}};
    else
      prescale <= prescale + 1'b1;
  end

  assign timer_tick = !aux_mode_select && prescale_hit(prescale, aux_input_select);

  // previous latch sample; software writes of the latch happen outside this
  // block and come without the wrap pulse
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      toggle_prev <= 1'b0;
    else
      toggle_prev <= core_toggle_latch;
  end

  // toggle edges qualified by the wrap pulse of the same cycle
  assign tog_rise = core_wrap && core_toggle_latch && !toggle_prev;
  assign tog_fall = core_wrap && !core_toggle_latch && toggle_prev;
  assign counter_tick = aux_mode_select && aux_input_select[2] &&
                        ((aux_input_select[0] && tog_rise) ||
                         (aux_input_select[1] && tog_fall));

  // capture pin synchroniser and edge detect
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_prev  <= 1'b0;
    end
    else
    begin
      pin_sync1 <= capture_trigger_pin;
      pin_sync2 <= pin_sync1;
      pin_prev  <= pin_sync2;
    end
  end

  // pin edges; the pin must stay put a few cycles to be seen
  assign pin_rise  = pin_sync2 && !pin_prev;
  assign pin_fall  = !pin_sync2 && pin_prev;
  assign cap_event = (capture_edge_select[0] && pin_rise) ||
                     (capture_edge_select[1] && pin_fall);

  // next timer value: software write first, then clear on capture, then tick
  always @*
  begin
    tick  = aux_run && (timer_tick || counter_tick);
    wraps = 1'b0;
    next_aux_timer = aux_timer;
    if (sw_timer_wr)
      next_aux_timer = wdata[WIDTH-1:0];
    else if (cap_event && capture_enable && clear_on_capture)
      next_aux_timer = {WIDTH{1'b0}};
    else if (tick)
    begin
      if (aux_direction)
      begin
        next_aux_timer = aux_timer - 1'b1;
        wraps = (aux_timer == {WIDTH{1'b0}});
      end
      else
      begin
        next_aux_timer = aux_timer + 1'b1;
        wraps = (aux_timer == {WIDTH{1'b1}});
      end
    end
  end

  // timer register
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      aux_timer <= {WIDTH{1'b0}};
    else
      aux_timer <= next_aux_timer;
  end

  // capture/reload register: capture latches the pre-clear value
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      capture_reload_reg <= {WIDTH{1'b0}};
    else if (cap_event && capture_enable)
      capture_reload_reg <= aux_timer;
    else if (wr_en && addr == `ATCR_ADDR_CAPTURE_RELOAD_REG)
      capture_reload_reg <= wdata[WIDTH-1:0];
  end

  // core reload port; core keeps its own wrap flag
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      core_load       <= 1'b0;
      core_load_value <= {WIDTH{1'b0}};
    end
    else
    begin
      core_load       <= core_wrap && core_reload_enable;
      core_load_value <= capture_reload_reg;
    end
  end

  // control and flag registers; hardware set wins over software clear
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_timer_control    <= `ATCR_CONTROL_RESET;
      aux_wrap_request     <= 1'b0;
      capture_request_flag <= 1'b0;
      aux_irq_enable       <= 1'b0;
      capture_irq_enable   <= 1'b0;
    end
    else
    begin
      if (wr_en && addr == `ATCR_ADDR_CONTROL)
        aux_timer_control <= wdata & `ATCR_CONTROL_MASK;
      if (wr_en && addr == `ATCR_ADDR_FLAGS)
      begin
        aux_wrap_request     <= wdata[`ATCR_FLAG_WRAP];
        capture_request_flag <= wdata[`ATCR_FLAG_CAPTURE];
        aux_irq_enable       <= wdata[`ATCR_FLAG_WRAP_EN];
        capture_irq_enable   <= wdata[`ATCR_FLAG_CAPTURE_EN];
      end
      if (wraps)
        aux_wrap_request <= 1'b1;
      if (cap_event)
        capture_request_flag <= 1'b1;
    end
  end

  // the block drives no toggle latch and no pin of its own
  assign aux_irq     = aux_wrap_request && aux_irq_enable;
  assign capture_irq = capture_request_flag && capture_irq_enable;

  // read data one cycle after the strobe; unmapped reads as zero
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (rd_en)
    begin
      case (addr)
        `ATCR_ADDR_CONTROL: rdata <= aux_timer_control;
        `ATCR_ADDR_TIMER:   rdata <= aux_timer;
        `ATCR_ADDR_CAPTURE_RELOAD_REG:  rdata <= capture_reload_reg;
        `ATCR_ADDR_FLAGS:   rdata <= {12'h000, capture_irq_enable, aux_irq_enable,
                                      capture_request_flag, aux_wrap_request};
        default:            rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end

endmodule
`default_nettype wire

// >>> tb/atcr_checker.sv
// port assertions for the auxiliary timer
`timescale 1ns/10ps
`default_nettype none
`include "atcr_defines.vh"
module atcr_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [15:0] addr,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] rdata,
  input wire logic        core_wrap,
  input wire logic        core_reload_enable,
  input wire logic        core_load,
  input wire logic        capture_trigger_pin,
  input wire logic        capture_irq
);
  logic [2:0] quiet;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // edges since the pin moved; the sync chain needs three, so seven leaves margin
  always @(posedge clock or negedge nrst)
    if (!nrst)
      quiet <= 3'h0;
    else if (capture_trigger_pin != $past(capture_trigger_pin))
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  chk_load_follow: assert property (core_wrap && core_reload_enable |=> core_load)
    else $error("core load missing");
  chk_load_cause: assert property (core_load |-> $past(core_wrap && core_reload_enable))
    else $error("core load without wrap");
  chk_load_off: assert property (core_wrap && !core_reload_enable |=> !core_load)
    else $error("load with reload off");
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data outside slot");
  chk_ctrl_rsvd: assert property ($past(rd_en && addr == `ATCR_ADDR_CONTROL) |-> (rdata & ~16'hf0cf) == 16'h0)
    else $error("reserved control bits set");
  chk_unmapped_zero: assert property ($past(rd_en && addr == 16'hff40) |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_flags_rsvd: assert property ($past(rd_en && addr == `ATCR_ADDR_FLAGS) |-> rdata[15:4] == 12'h000)
    else $error("reserved flag bits set");
  chk_cap_quiet: assert property (quiet == 3'h7 && !$past(wr_en) |-> $stable(capture_irq))
    else $error("capture irq moved without cause");
endmodule
bind atcr_aux_timer atcr_checker atcr_checker_inst (.clock, .nrst, .addr, .wr_en, .rd_en, .rdata, .core_wrap,
  .core_reload_enable, .core_load, .capture_trigger_pin, .capture_irq);
`default_nettype wire

// >>> tb/atcr_core_model.sv
// core timer side: toggle latch, wrap pulses and a log of reloads
`timescale 1ns/10ps
`default_nettype none
module atcr_core_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        go_wrap,
  input  wire logic        go_sw,
  input  wire logic        core_load,
  input  wire logic [15:0] core_load_value,
  output logic             core_toggle_latch,
  output logic             core_wrap,
  output int               n_loads,
  output logic [15:0]      last_load
);
  // a software toggle moves the latch with no wrap pulse, which must not count
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      core_toggle_latch <= 1'b0;
      core_wrap <= 1'b0;
      n_loads <= 0;
      last_load <= 16'h0000;
    end
    else
    begin
      core_wrap <= go_wrap;
      core_toggle_latch <= core_toggle_latch ^ (go_wrap | go_sw);
      n_loads <= n_loads + core_load;
      last_load <= core_load ? core_load_value : last_load;
    end
endmodule
`default_nettype wire

// >>> tb/atcr_aux_timer_tb.sv
// self-checking bench for the auxiliary timer
`timescale 1ns/10ps
`default_nettype none
`include "atcr_defines.vh"
module atcr_aux_timer_tb;
  logic        clock = 0, nrst = 0, wr_en = 0, rd_en = 0, go_wrap = 0, go_sw = 0;
  logic        core_reload_enable = 0, capture_trigger_pin = 0;
  logic        core_toggle_latch, core_wrap, core_load, aux_irq, capture_irq;
  logic [15:0] addr = 0, wdata = 0, rdata, core_load_value, last_load, d, a, v;
  int          n_errors = 0, n_checks = 0, n_loads, i, e, k;
  always #2.5 clock = ~clock;
  atcr_aux_timer atcr_aux_timer_inst (.clock, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .core_toggle_latch,
    .core_wrap, .core_reload_enable, .core_load, .core_load_value, .capture_trigger_pin, .aux_irq, .capture_irq);
  atcr_core_model atcr_core_model_inst (.clock, .nrst, .go_wrap, .go_sw, .core_load, .core_load_value,
    .core_toggle_latch, .core_wrap, .n_loads, .last_load);
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [15:0] ad, input logic [15:0] dt);
    @(posedge clock);
    {wr_en, addr, wdata} <= {1'b1, ad, dt};
    @(posedge clock);
    wr_en <= 0;
  endtask
  task rd(input logic [15:0] ad);
    @(posedge clock);
    {rd_en, addr} <= {1'b1, ad};
    @(posedge clock);
    rd_en <= 0;
    #1 d = rdata;
  endtask
  // a core latch change, by wrap or by software, then time to settle
  task pulse(input logic sw);
    @(posedge clock);
    {go_wrap, go_sw} <= {!sw, sw};
    @(posedge clock);
    {go_wrap, go_sw} <= 2'b00;
    repeat (4) @(posedge clock);
  endtask
  initial
  begin
    #400000;
    n_errors++;
    results;
  end
  initial
  begin
    void'($urandom(75));
    v = $urandom;
    repeat (20) @(posedge clock);
    nrst <= 1;
    rd(`ATCR_ADDR_CONTROL); chk(d, 16'h0000);
    wr(`ATCR_ADDR_CONTROL, 16'hffff); rd(`ATCR_ADDR_CONTROL); chk(d, 16'hf0cf);
    rd(16'hff40); chk(d, 16'h0000);
    // free prescaler: reads whole periods apart differ by exactly two ticks, or by none with run off
    for (i = 0; i < 9; i++)
    begin
      k = 8 << i[2:0];
      wr(`ATCR_ADDR_TIMER, v);
      wr(`ATCR_ADDR_CONTROL, {8'h00, i[0], i < 8, 3'h0, i[2:0]});
      rd(`ATCR_ADDR_TIMER); a = d;
      repeat (2 * k - 2) @(posedge clock);
      rd(`ATCR_ADDR_TIMER); chk(d - a, i == 8 ? 16'h0 : i[0] ? 16'hfffe : 16'h0002);
    end
    for (i = 0; i < 2; i++)
    begin
      wr(`ATCR_ADDR_FLAGS, 16'h0000);
      wr(`ATCR_ADDR_TIMER, i ? 16'h0000 : 16'hffff);
      wr(`ATCR_ADDR_CONTROL, {8'h00, i[0], 1'b1, 6'h00});
      repeat (12) @(posedge clock);
      wr(`ATCR_ADDR_CONTROL, 16'h0000);
      rd(`ATCR_ADDR_FLAGS); chk(d, 16'h0001);
      chk(aux_irq, 1'b0);
      wr(`ATCR_ADDR_FLAGS, 16'h0005); #1 chk(aux_irq, 1'b1);
    end
    // chained count: two wraps then two software toggles per selection
    wr(`ATCR_ADDR_CAPTURE_RELOAD_REG, v);
    for (i = 0; i < 8; i++)
    begin
      e = n_loads;
      core_reload_enable <= i[0];
      wr(`ATCR_ADDR_TIMER, 16'h0000);
      wr(`ATCR_ADDR_CONTROL, {8'h00, 1'b0, 1'b1, 2'h0, 1'b1, i[2:0]});
      for (k = 0; k < 4; k++) pulse(k > 1);
      rd(`ATCR_ADDR_TIMER); chk(d, i[2] ? i[0] + i[1] : 0);
      chk(n_loads - e, 2 * i[0]);
    end
    chk(last_load, v);
    // one rise and one fall per pass with the timer held
    for (i = 0; i < 16; i++)
    begin
      v = $urandom;
      e = i[0] + i[1];
      wr(`ATCR_ADDR_FLAGS, 16'h0000);
      wr(`ATCR_ADDR_CAPTURE_RELOAD_REG, 16'h0000);
      wr(`ATCR_ADDR_TIMER, v);
      wr(`ATCR_ADDR_CONTROL, {i[3:0], 12'h000});
      for (k = 0; k < 2; k++)
      begin
        @(posedge clock);
        capture_trigger_pin <= !capture_trigger_pin;
        repeat (6) @(posedge clock);
      end
      rd(`ATCR_ADDR_FLAGS); chk(d[1], e > 0);
      rd(`ATCR_ADDR_CAPTURE_RELOAD_REG); chk(d, i[3] && e ? (i[2] && e == 2 ? 16'h0 : v) : 16'h0);
      rd(`ATCR_ADDR_TIMER); chk(d, i[3] && e && i[2] ? 16'h0 : v);
    end
    wr(`ATCR_ADDR_FLAGS, 16'h000a); #1 chk(capture_irq, 1'b1);
    results;
  end
endmodule
`default_nettype wire
